// [hw/swc_pkg.sv]
// types shared by the sleep and wake controller
// assumes nothing of its surroundings
package swc_pkg;
  typedef enum logic [1:0] {
    SWC_RUN = 2'b00,
    SWC_HALT = 2'b01,
    SWC_SETTLE = 2'b10
  } swc_state_t;
endpackage

// [hw/swc_regs.svh]
// register indices, field positions, reset values and timing counts
// of the sleep and wake controller; included by its bare name
`ifndef SWC_REGS_SVH
`define SWC_REGS_SVH

// -----------------------------------------------------------------
// register indices, byte address is four times the index
// -----------------------------------------------------------------
`define SWC_IDX_STATUS 8'h03
`define SWC_IDX_INTCTL 8'h0B
`define SWC_IDX_PIRQF 8'h0C
`define SWC_IDX_PIRQE 8'h8C
`define SWC_IDX_PWRCTL 8'h8E

// -----------------------------------------------------------------
// field positions
// -----------------------------------------------------------------
`define SWC_ST_TO 4
`define SWC_ST_PD 3
`define SWC_IC_GIE 7
`define SWC_IC_PEIE 6
`define SWC_IC_T0IE 5
`define SWC_IC_INTE 4
`define SWC_IC_GPIE 3
`define SWC_IC_T0IF 2
`define SWC_IC_INTF 1
`define SWC_IC_GPIF 0
`define SWC_PF_AD 6
`define SWC_PF_CCP 5
`define SWC_PF_CMP 3
`define SWC_PF_TMR2 1
`define SWC_PF_TMR1 0
`define SWC_PC_BOR 0

// -----------------------------------------------------------------
// reset values and masks
// -----------------------------------------------------------------
`define SWC_ST_POR 8'h18
`define SWC_ST_WMASK 8'hE7
`define SWC_IC_RST 8'h00
`define SWC_PF_RST 8'h00
`define SWC_PF_MASK 8'h6B
`define SWC_PC_POR 8'h00
`define SWC_PC_MASK 8'h03

// -----------------------------------------------------------------
// timing
// -----------------------------------------------------------------
`define SWC_CLK_NS 50
`define SWC_SETTLE_NS 1000
`define SWC_SETTLE_CYC ((`SWC_SETTLE_NS + `SWC_CLK_NS - 1) / `SWC_CLK_NS)
`define SWC_RESP_OKAY 2'b00
`define SWC_RESP_SLVERR 2'b10

`endif

// [hw/swc_sleep_wake_controller.sv]
// sleep and wake sequencer with its status and interrupt registers
// assumes one core clock, an axi4-lite master and an outside watchdog
`timescale 1ns/100ps
`include "swc_regs.svh"

module swc_sleep_wake_controller #(
  parameter int PC_W = 13,
  parameter int SETTLE_CYC = `SWC_SETTLE_CYC
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic halt_exec,
  input wire logic watchdog_clear_instruction,
  input wire logic [PC_W-1:0] pc_in,
  output logic prefetch_valid,
  output logic [PC_W-1:0] prefetch_addr,
  input wire logic watchdog_enable,
  input wire logic watchdog_timeout,
  output logic watchdog_clear,
  output logic prescaler_clear,
  output logic watchdog_run,
  input wire logic bor_event,
  input wire logic master_clear_pin_i,
  output logic master_clear_pin_o,
  output logic master_clear_pin_oe,
  input wire logic ext_int_pin,
  input wire logic port_change_evt,
  input wire logic t0_ovf_evt,
  input wire logic tmr1_evt,
  input wire logic tmr1_async,
  input wire logic ccp_evt,
  input wire logic ccp_capture_mode,
  input wire logic adc_evt,
  input wire logic adc_rc_clock,
  input wire logic cmp_evt,
  input wire logic tmr2_evt,
  output logic osc_enable,
  output logic core_run,
  output logic io_hold,
  output logic device_reset,
  output logic resume_exec,
  output logic vector_after_next
);

  // -----------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------
  // byte address to register index, shared by both bus channels
  function automatic logic [7:0] swc_index(input logic [11:0] a);
    swc_index = a[9:2];
  endfunction

  function automatic logic swc_mapped(input logic [11:0] a);
    logic [7:0] i;
    i = a[9:2];
    swc_mapped = (a[11:10] == 2'b00) && (a[1:0] == 2'b00) &&
      (i == `SWC_IDX_STATUS || i == `SWC_IDX_INTCTL ||
       i == `SWC_IDX_PIRQF || i == `SWC_IDX_PIRQE ||
       i == `SWC_IDX_PWRCTL);
  endfunction

  // -----------------------------------------------------------------
  // state and registers
  // -----------------------------------------------------------------
  swc_pkg::swc_state_t state_q;
  logic [7:0] settle_q;
  logic [7:0] status_q;
  logic [7:0] intctl_q;
  logic [7:0] pirqf_q;
  logic [7:0] pirqe_q;
  logic [7:0] pwrctl_q;
  logic master_clear_pin_s1_q, master_clear_pin_s2_q;
  logic int_s1_q, int_s2_q, int_s3_q;
  logic wdt_clr_q, pre_clr_q, wdt_run_q;
  logic reset_q, resume_q, vector_q, pf_valid_q;
  logic [PC_W-1:0] pf_addr_q;
  logic aw_hold_q, w_hold_q, bvalid_q, rvalid_q;
  logic [11:0] awaddr_q;
  logic [7:0] wdata_q;
  logic wstrb_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;

  logic running, halted_now, master_clear_pin_low, rst_evt, wake_pend;
  logic enter, wake_int, wake_wdt, wake_any, wr_go;
  logic [7:0] wr_idx;
  logic [7:0] ic_set, pf_set;

  // -----------------------------------------------------------------
  // pin synchronisers
  // -----------------------------------------------------------------
  // only the second stage is read, the third is for edge detection
  always_ff @(posedge clock) begin
    if (rst) begin
      master_clear_pin_s1_q <= 1'b1;
      master_clear_pin_s2_q <= 1'b1;
      int_s1_q <= 1'b0;
      int_s2_q <= 1'b0;
      int_s3_q <= 1'b0;
    end else begin
      master_clear_pin_s1_q <= master_clear_pin_i;
      master_clear_pin_s2_q <= master_clear_pin_s1_q;
      int_s1_q <= ext_int_pin;
      int_s2_q <= int_s1_q;
      int_s3_q <= int_s2_q;
    end
  end

  // -----------------------------------------------------------------
  // wake and entry decisions
  // -----------------------------------------------------------------
  assign running = (state_q == swc_pkg::SWC_RUN);
  assign halted_now = (state_q == swc_pkg::SWC_HALT);
  assign master_clear_pin_low = ~master_clear_pin_s2_q;
  // a running watchdog time-out resets the core; the pin is only sensed
  assign rst_evt = master_clear_pin_low | (running & watchdog_enable & watchdog_timeout);
  // global enable is deliberately left out of the wake term
  assign wake_pend =
    (intctl_q[`SWC_IC_INTE] & intctl_q[`SWC_IC_INTF]) |
    (intctl_q[`SWC_IC_GPIE] & intctl_q[`SWC_IC_GPIF]) |
    (intctl_q[`SWC_IC_T0IE] & intctl_q[`SWC_IC_T0IF]) |
    (intctl_q[`SWC_IC_PEIE] & |(pirqe_q & pirqf_q));
  // a pending enabled interrupt turns the halt into a no-op
  assign enter = running & halt_exec & ~wake_pend & ~rst_evt;
  // pending check is re-run in halt, so a late arrival wakes at once
  assign wake_int = halted_now & ~master_clear_pin_low & wake_pend;
  assign wake_wdt = halted_now & ~master_clear_pin_low & ~wake_pend &
    watchdog_enable & watchdog_timeout;
  assign wake_any = wake_int | wake_wdt | (halted_now & master_clear_pin_low);

  // -----------------------------------------------------------------
  // sequencer
  // -----------------------------------------------------------------
  // settle length trades wake latency for a stable clock
  always_ff @(posedge clock) begin
    if (rst) begin
      state_q <= swc_pkg::SWC_RUN;
      settle_q <= 8'h00;
    end else begin
      case (state_q)
        swc_pkg::SWC_RUN: begin
          if (enter) begin
            state_q <= swc_pkg::SWC_HALT;
          end
        end
        swc_pkg::SWC_HALT: begin
          if (master_clear_pin_low) begin
            state_q <= swc_pkg::SWC_RUN;
          end else if (wake_int || wake_wdt) begin
            state_q <= swc_pkg::SWC_SETTLE;
            settle_q <= 8'(SETTLE_CYC - 1);
          end
        end
        swc_pkg::SWC_SETTLE: begin
          if (master_clear_pin_low) begin
            state_q <= swc_pkg::SWC_RUN;
          end else if (settle_q == 8'h00) begin
            state_q <= swc_pkg::SWC_RUN;
          end else begin
            settle_q <= settle_q - 8'h01;
          end
        end
        default: begin
          state_q <= swc_pkg::SWC_RUN;
        end
      endcase
    end
  end

  // oscillator and pin hold follow the state register
  assign osc_enable = ~halted_now;
  assign core_run = running;
  assign io_hold = ~running;
  // open-drain pin is never driven by this block
  assign master_clear_pin_o = 1'b0;
  assign master_clear_pin_oe = 1'b0;

  // -----------------------------------------------------------------
  // resume, vector and reset pulses
  // -----------------------------------------------------------------
  // the core runs the prefetched word, then vectors when global
  // interrupts were enabled at the last interrupt wake
  always_ff @(posedge clock) begin
    if (rst) begin
      resume_q <= 1'b0;
      vector_q <= 1'b0;
      reset_q <= 1'b0;
    end else begin
      resume_q <= (state_q == swc_pkg::SWC_SETTLE) &&
        (settle_q == 8'h00) && !master_clear_pin_low;
      if (state_q == swc_pkg::SWC_HALT && wake_int) begin
        vector_q <= intctl_q[`SWC_IC_GIE];
      end else if (resume_q) begin
        vector_q <= 1'b0;
      end
      reset_q <= rst_evt;
    end
  end

  assign resume_exec = resume_q;
  assign vector_after_next = vector_q & resume_q;
  assign device_reset = reset_q;

  // -----------------------------------------------------------------
  // watchdog control and prefetch
  // -----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      wdt_clr_q <= 1'b0;
      pre_clr_q <= 1'b0;
      wdt_run_q <= 1'b0;
      pf_valid_q <= 1'b0;
      pf_addr_q <= '0;
    end else begin
      // cleared on halt entry and on every wake, not on a no-op halt
      wdt_clr_q <= enter | wake_any | watchdog_clear_instruction;
      pre_clr_q <= enter | wake_any | watchdog_clear_instruction;
      wdt_run_q <= watchdog_enable;
      pf_valid_q <= running & halt_exec;
      if (running && halt_exec) begin
        pf_addr_q <= pc_in + PC_W'(1);
      end
    end
  end

  assign watchdog_clear = wdt_clr_q;
  assign prescaler_clear = pre_clr_q;
  assign watchdog_run = wdt_run_q;
  assign prefetch_valid = pf_valid_q;
  assign prefetch_addr = pf_addr_q;

  // -----------------------------------------------------------------
  // axi4-lite write channel
  // -----------------------------------------------------------------
  // address and data are taken in either order, one write at a time
  assign s_axi_awready = ~aw_hold_q & ~bvalid_q;
  assign s_axi_wready = ~w_hold_q & ~bvalid_q;
  assign wr_go = aw_hold_q & w_hold_q & ~bvalid_q;
  assign wr_idx = swc_index(awaddr_q);

  always_ff @(posedge clock) begin
    if (rst) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= `SWC_RESP_OKAY;
      awaddr_q <= 12'h000;
      wdata_q <= 8'h00;
      wstrb_q <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        wdata_q <= s_axi_wdata[7:0];
        wstrb_q <= s_axi_wstrb[0];
      end
      if (wr_go) begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= swc_mapped(awaddr_q) ? `SWC_RESP_OKAY : `SWC_RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  // -----------------------------------------------------------------
  // interrupt flag sources
  // -----------------------------------------------------------------
  // clocked sources are gated off outside run asynchronous
  // ones only in their wake-capable modes
  always_comb begin
    ic_set = 8'h00;
    pf_set = 8'h00;
    ic_set[`SWC_IC_INTF] = int_s2_q & ~int_s3_q;
    ic_set[`SWC_IC_GPIF] = port_change_evt;
    ic_set[`SWC_IC_T0IF] = t0_ovf_evt & running;
    pf_set[`SWC_PF_TMR1] = tmr1_evt & (running | tmr1_async);
    pf_set[`SWC_PF_CCP] = ccp_evt & (running | ccp_capture_mode);
    pf_set[`SWC_PF_AD] = adc_evt & (running | adc_rc_clock);
    pf_set[`SWC_PF_CMP] = cmp_evt;
    pf_set[`SWC_PF_TMR2] = tmr2_evt & running;
  end

  // -----------------------------------------------------------------
  // interrupt registers
  // -----------------------------------------------------------------
  // a hardware set in the same cycle as a software clear wins
  always_ff @(posedge clock) begin
    if (rst || reset_q) begin
      intctl_q <= `SWC_IC_RST;
      pirqf_q <= `SWC_PF_RST;
      pirqe_q <= `SWC_PF_RST;
    end else begin
      if (wr_go && wstrb_q && wr_idx == `SWC_IDX_INTCTL) begin
        intctl_q <= wdata_q | ic_set;
      end else begin
        intctl_q <= intctl_q | ic_set;
      end
      if (wr_go && wstrb_q && wr_idx == `SWC_IDX_PIRQF) begin
        pirqf_q <= (wdata_q & `SWC_PF_MASK) | pf_set;
      end else begin
        pirqf_q <= pirqf_q | pf_set;
      end
      if (wr_go && wstrb_q && wr_idx == `SWC_IDX_PIRQE) begin
        pirqe_q <= wdata_q & `SWC_PF_MASK;
      end
    end
  end

  // -----------------------------------------------------------------
  // core status flags
  // -----------------------------------------------------------------
  // a master clear leaves the two flags alone so software can tell it
  // from a watchdog reset; a set flag after halt means a no-op
  always_ff @(posedge clock) begin
    if (rst) begin
      status_q <= `SWC_ST_POR;
    end else begin
      if (wr_go && wstrb_q && wr_idx == `SWC_IDX_STATUS) begin
        status_q <= (status_q & ~`SWC_ST_WMASK) | (wdata_q & `SWC_ST_WMASK);
      end
      if (reset_q) begin
        status_q[7:5] <= 3'b000;
      end
      if (running && watchdog_enable && watchdog_timeout && !master_clear_pin_low) begin
        status_q[`SWC_ST_TO] <= 1'b0;
        status_q[`SWC_ST_PD] <= 1'b1;
      end else if (enter) begin
        status_q[`SWC_ST_TO] <= 1'b1;
        status_q[`SWC_ST_PD] <= 1'b0;
      end else if (wake_wdt) begin
        status_q[`SWC_ST_TO] <= 1'b0;
      end else if (watchdog_clear_instruction && running) begin
        status_q[`SWC_ST_TO] <= 1'b1;
        status_q[`SWC_ST_PD] <= 1'b1;
      end
    end
  end

  // -----------------------------------------------------------------
  // power control
  // -----------------------------------------------------------------
  // brown-out beats a software write; apart from power-on, no other reset touches bit 0
  always_ff @(posedge clock) begin
    if (rst) begin
      pwrctl_q <= `SWC_PC_POR;
    end else begin
      if (wr_go && wstrb_q && wr_idx == `SWC_IDX_PWRCTL) begin
        pwrctl_q <= wdata_q & `SWC_PC_MASK;
      end
      if (bor_event) begin
        pwrctl_q[`SWC_PC_BOR] <= 1'b0;
      end
    end
  end

  // -----------------------------------------------------------------
  // axi4-lite read channel
  // -----------------------------------------------------------------
  assign s_axi_arready = ~rvalid_q;

  always_ff @(posedge clock) begin
    if (rst) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= `SWC_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        rvalid_q <= 1'b1;
        rresp_q <= swc_mapped(s_axi_araddr) ? `SWC_RESP_OKAY : `SWC_RESP_SLVERR;
        case (swc_index(s_axi_araddr))
          `SWC_IDX_STATUS: rdata_q <= {24'h000000, status_q};
          `SWC_IDX_INTCTL: rdata_q <= {24'h000000, intctl_q};
          `SWC_IDX_PIRQF: rdata_q <= {24'h000000, pirqf_q};
          `SWC_IDX_PIRQE: rdata_q <= {24'h000000, pirqe_q};
          `SWC_IDX_PWRCTL: rdata_q <= {24'h000000, pwrctl_q};
          default: rdata_q <= 32'h0000_0000;
        endcase
        if (!swc_mapped(s_axi_araddr)) begin
          rdata_q <= 32'h0000_0000;
        end
      end else if (rvalid_q && s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // -----------------------------------------------------------------
  // assertions
  // -----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  property p_halt_only_instr;
    (halted_now && $past(state_q) == swc_pkg::SWC_RUN) |-> $past(halt_exec);
  endproperty
  a_halt_only_instr: assert property (p_halt_only_instr)
    else $error("halt entered without halt instruction");

  property p_enter_clears;
    enter |=> (watchdog_clear && prescaler_clear && watchdog_run == $past(watchdog_enable));
  endproperty
  a_enter_clears: assert property (p_enter_clears)
    else $error("halt entry did not clear watchdog");

  property p_enter_flags;
    enter |=> (status_q[`SWC_ST_TO] && !status_q[`SWC_ST_PD] && !osc_enable);
  endproperty
  a_enter_flags: assert property (p_enter_flags)
    else $error("halt entry flags or oscillator wrong");

  property p_osc_off;
    halted_now |-> (!osc_enable && io_hold && !core_run);
  endproperty
  a_osc_off: assert property (p_osc_off)
    else $error("oscillator or pin hold wrong in halt");

  property p_no_master_clear_pin_drive;
    watchdog_timeout |=> !master_clear_pin_oe;
  endproperty
  a_no_master_clear_pin_drive: assert property (p_no_master_clear_pin_drive)
    else $error("master clear pin driven");

  // a master clear during settle ends the wake by reset instead
  property p_int_wake;
    disable iff (rst || master_clear_pin_low)
    wake_int |=> (state_q == swc_pkg::SWC_SETTLE) ##[1:300] resume_exec;
  endproperty
  a_int_wake: assert property (p_int_wake)
    else $error("interrupt wake did not resume");

  property p_master_clear_pin_wake;
    (halted_now && master_clear_pin_low) |=> (device_reset && running);
  endproperty
  a_master_clear_pin_wake: assert property (p_master_clear_pin_wake)
    else $error("master clear wake did not reset");

  property p_wdt_wake_to;
    wake_wdt |=> (!status_q[`SWC_ST_TO] && watchdog_clear);
  endproperty
  a_wdt_wake_to: assert property (p_wdt_wake_to)
    else $error("watchdog wake flags wrong");

  property p_prefetch;
    (running && halt_exec) |=> (prefetch_valid && prefetch_addr == $past(pc_in) + PC_W'(1));
  endproperty
  a_prefetch: assert property (p_prefetch)
    else $error("prefetch address wrong");

  property p_nop_halt;
    (running && halt_exec && wake_pend && !rst_evt && !watchdog_clear_instruction)
      |=> (running && !watchdog_clear && $stable(status_q[`SWC_ST_PD]));
  endproperty
  a_nop_halt: assert property (p_nop_halt)
    else $error("no-op halt had side effects");

  property p_vector;
    (halted_now && wake_int) |=> (vector_q == $past(intctl_q[`SWC_IC_GIE]));
  endproperty
  a_vector: assert property (p_vector)
    else $error("vector choice does not follow global enable");

  property p_bor;
    bor_event |=> !pwrctl_q[`SWC_PC_BOR];
  endproperty
  a_bor: assert property (p_bor)
    else $error("brown-out did not clear bit 0");

endmodule // swc_sleep_wake_controller

// [tb/sleep_wake_controller_test.sv]
// self-checking bench for the sleep and wake controller, register reads scored from a queue
// assumes the controller's register header and a 20 MHz core clock
`timescale 1ns/100ps
`include "swc_regs.svh"
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin n_fail++; \
  $display("ERROR %s exp %0h got %0h", n, e, a); end end

module sleep_wake_controller_test;
  logic clock = 0, rst = 1, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, hx = 0, wci = 0;
  logic wen = 1, wto = 0, bor = 0, master_clear_pin = 1, xint = 0, ta, tw, tb, da, dw;
  logic [11:0] awa = 0, ara = 0;
  logic [31:0] wd = 0;
  logic [12:0] pc = 0;
  logic [6:0] ev = 0;
  logic [2:0] md = 0;
  logic [9:0] exq[$];
  logic [9:0] ex;
  logic [1:0] eb, bq[$];
  logic [7:0] rw, r;
  wire awr, wrd, bv, arr, rv, pv, wcl, psc, wrn, mo, moe, osc, crun, ioh, drst, res, vec;
  wire [1:0] br, rr;
  wire [31:0] rdd;
  wire [12:0] pa;
  int n_fail = 0, num_checks = 0, cyc = 0, i, k;

  // short settle keeps each wake brief; expectations do not depend on it
  swc_sleep_wake_controller #(.PC_W(13), .SETTLE_CYC(4)) i_dut (.clock(clock), .rst(rst),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(br),
    .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdd), .s_axi_rresp(rr), .s_axi_rvalid(rv),
    .s_axi_rready(rry), .halt_exec(hx), .watchdog_clear_instruction(wci), .pc_in(pc),
    .prefetch_valid(pv), .prefetch_addr(pa), .watchdog_enable(wen), .watchdog_timeout(wto),
    .watchdog_clear(wcl), .prescaler_clear(psc), .watchdog_run(wrn), .bor_event(bor),
    .master_clear_pin_i(master_clear_pin), .master_clear_pin_o(mo), .master_clear_pin_oe(moe),
    .ext_int_pin(xint), .port_change_evt(ev[0]), .t0_ovf_evt(ev[2]), .tmr1_evt(ev[3]),
    .tmr1_async(md[0]), .ccp_evt(ev[4]), .ccp_capture_mode(md[1]), .adc_evt(ev[5]),
    .adc_rc_clock(md[2]), .cmp_evt(ev[1]), .tmr2_evt(ev[6]), .osc_enable(osc),
    .core_run(crun), .io_hold(ioh), .device_reset(drst), .resume_exec(res),
    .vector_after_next(vec));

  // -----------------------------------------------------------------
  // clock, hang guard and verdict
  // -----------------------------------------------------------------
  always #25 clock = ~clock;

  // the run needs well under a thousand cycles, so a limit of 4000 only trips on a hang
  always @(posedge clock) begin
    cyc++;
    if (cyc == 4000) begin
      n_fail++;
      summarize;
    end
  end

  task summarize;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // read data and responses are scored mid-cycle, away from the edge that moves them
  always @(negedge clock) begin
    if (rv === 1'b1 && rry === 1'b1) begin
      ex = exq.pop_front();
      `CHK("rdata", {24'h0, ex[7:0]}, rdd)
      `CHK("rresp", ex[9:8], rr)
    end
    if (bv === 1'b1 && bry === 1'b1) begin
      eb = bq.pop_front();
      `CHK("bresp", eb, br)
    end
  end

  // -----------------------------------------------------------------
  // bus and core tasks
  // -----------------------------------------------------------------
  task rd(input logic [7:0] ix, input logic [7:0] e);
    @(posedge clock);
    ara <= {2'b0, ix, 2'b0};
    arv <= 1;
    rry <= 1;
    exq.push_back({((ix == 8'h40) ? `SWC_RESP_SLVERR : `SWC_RESP_OKAY), e});
    do begin @(negedge clock); ta = arr; @(posedge clock); end while (ta !== 1'b1);
    arv <= 0;
    do begin @(negedge clock); tb = rv; @(posedge clock); end while (tb !== 1'b1);
    rry <= 0;
  endtask

  // address and data are released each on its own acceptance
  task wr(input logic [7:0] ix, input logic [7:0] d);
    @(posedge clock);
    awa <= {2'b0, ix, 2'b0};
    wd <= {24'h0, d};
    awv <= 1;
    wv <= 1;
    bry <= 1;
    bq.push_back((ix == 8'h40) ? `SWC_RESP_SLVERR : `SWC_RESP_OKAY);
    da = 0;
    dw = 0;
    do begin
      @(negedge clock);
      ta = awr & awv;
      tw = wrd & wv;
      @(posedge clock);
      if (ta) awv <= 0;
      if (tw) wv <= 0;
      da = da | ta;
      dw = dw | tw;
    end while (!(da && dw));
    do begin @(negedge clock); tb = bv; @(posedge clock); end while (tb !== 1'b1);
    bry <= 0;
  endtask

  // master clear stays high through every halt unless a test pulls it
  // the word after halt is never run here, as if software put a no-op there
  task halt;
    @(posedge clock);
    hx <= 1;
    @(posedge clock);
    hx <= 0;
  endtask

  task wake(input logic v);
    for (i = 0; i < 200 && res !== 1'b1; i++) begin @(posedge clock); #1; end
    `CHK("resume_exec", 1'b1, res)
    `CHK("vector_after_next", v, vec)
  endtask

  // -----------------------------------------------------------------
  // scenarios
  // -----------------------------------------------------------------
  initial begin
    void'($urandom(88241));
    repeat (6) @(posedge clock);
    rst <= 0;
    rd(`SWC_IDX_STATUS, `SWC_ST_POR);
    rd(`SWC_IDX_PWRCTL, `SWC_PC_POR);
    wr(8'h40, 8'hFF);
    rd(8'h40, 8'h00);
    r = 8'($urandom());
    wr(`SWC_IDX_STATUS, r);
    rw = r & `SWC_ST_WMASK;
    rd(`SWC_IDX_STATUS, rw | 8'h18);
    $display("test reset values done");
    // pin change with global enable off, then comparator with it on;
    // clocked or wrongly moded sources pulse first and must not wake
    for (k = 0; k < 2; k++) begin
      pc <= 13'($urandom());
      wr(`SWC_IDX_INTCTL, k ? 8'hE0 : 8'h08);
      wr(`SWC_IDX_PIRQE, k ? 8'h6B : 8'h08);
      halt;
      #1;
      `CHK("osc_enable", 1'b0, osc)
      `CHK("core_run", 1'b0, crun)
      `CHK("io_hold", 1'b1, ioh)
      `CHK("prefetch_addr", 13'(pc + 13'h1), pa)
      `CHK("prefetch_valid", 1'b1, pv)
      `CHK("watchdog_clear", 1'b1, wcl)
      `CHK("watchdog_run", 1'b1, wrn)
      rd(`SWC_IDX_STATUS, rw | 8'h10);
      @(posedge clock);
      ev <= 7'h7C;
      @(posedge clock);
      ev <= 0;
      @(posedge clock);
      #1;
      `CHK("osc_enable", 1'b0, osc)
      @(posedge clock);
      ev[k] <= 1;
      @(posedge clock);
      ev[k] <= 0;
      wake(k[0]);
      $display("test interrupt wake %0d done", k);
    end
    // a flag still pending turns the next halt into a no-op
    @(posedge clock);
    wci <= 1;
    halt;
    wci <= 0;
    #1;
    `CHK("core_run", 1'b1, crun)
    rd(`SWC_IDX_STATUS, rw | 8'h18);
    wr(`SWC_IDX_INTCTL, 8'h00);
    halt;
    @(posedge clock);
    wto <= 1;
    @(posedge clock);
    wto <= 0;
    wake(1'b0);
    rd(`SWC_IDX_STATUS, rw);
    $display("test no-op and watchdog wake done");
    wr(`SWC_IDX_PWRCTL, 8'h03);
    @(posedge clock);
    bor <= 1;
    @(posedge clock);
    bor <= 0;
    rd(`SWC_IDX_PWRCTL, 8'h02);
    // master clear while halted resets instead of resuming
    halt;
    @(posedge clock);
    master_clear_pin <= 0;
    repeat (4) @(posedge clock);
    #1;
    `CHK("device_reset", 1'b1, drst)
    `CHK("core_run", 1'b1, crun)
    `CHK("master_clear_pin_oe", 1'b0, moe)
    `CHK("master_clear_pin_o", 1'b0, mo)
    @(posedge clock);
    master_clear_pin <= 1;
    repeat (4) @(posedge clock);
    rd(`SWC_IDX_PIRQE, 8'h00);
    rd(`SWC_IDX_STATUS, (rw & 8'h07) | 8'h10);
    $display("test brown-out and master clear done");
    summarize;
  end
endmodule // sleep_wake_controller_test
